// [hdl/bbx_exec.sv]
`timescale 1ns/1ps
module bbx_exec
	import bbx_pkg::*;
(
	input wire logic CLK, // 50 MHz core clock
	input wire logic RST_N, // Async reset, active low
	input wire bbx_instr_t INSTR, // Decoded instruction, valid per cycle
	input wire logic [7:0] FREG_RDATA, // Contents of file register INSTR.faddr
	input wire logic [7:0] ACC, // Accumulator
	input wire logic [7:0] PC_HIGH_LATCH, // Program counter high latch
	output logic [PC_W-1:0] PC, // Program counter
	output logic FLUSH, // Next fetched instruction becomes a no-op
	output bbx_fwrite_t FWRITE, // File register write port
	output bbx_push_t STACK_PUSH, // Push onto stack_top
	output logic FLAGS_WE // Status flag write, never raised here
);

	logic [PC_W-1:0] pc_q, pc_d;
	logic flush_q, flush_d;
	bbx_fwrite_t fwrite_q, fwrite_d;
	bbx_push_t push_q, push_d;
	logic [PC_W-1:0] pc_inc;
	logic tested;
	logic exec;

	function automatic logic [7:0] bit_mask(input logic [2:0] pos);
		bit_mask = 8'h01 << pos;
	endfunction : bit_mask

	assign pc_inc = pc_q + 15'h0001;
	// Read data is this cycle's; a write issued last cycle must already be visible
	assign tested = FREG_RDATA[INSTR.bit_pos];
	// A flushed slot is ignored even if the fetch path still marks it valid
	assign exec = INSTR.valid && !flush_q;

	always_comb
	begin
		pc_d = pc_inc;
		flush_d = 1'b0;
		fwrite_d = '0;
		push_d = '0;
		if (exec)
		begin
			unique case (INSTR.op)
				OP_CLEAR_BIT:
				begin
					fwrite_d.wr = 1'b1;
					fwrite_d.addr = INSTR.faddr;
					fwrite_d.data = FREG_RDATA & ~bit_mask(INSTR.bit_pos);
				end
				OP_SET_BIT:
				begin
					fwrite_d.wr = 1'b1;
					fwrite_d.addr = INSTR.faddr;
					fwrite_d.data = FREG_RDATA | bit_mask(INSTR.bit_pos);
				end
				OP_TEST_SKIP_CLEAR:
					flush_d = !tested;
				OP_TEST_SKIP_SET:
					flush_d = tested;
				OP_JUMP_LITERAL:
				begin
					// Two's-complement wrap keeps the sum within the 15-bit space
					pc_d = pc_inc + PC_W'({{(PC_W-REL_W){INSTR.rel_k[REL_W-1]}}, INSTR.rel_k});
					flush_d = 1'b1;
				end
				OP_JUMP_ACC:
				begin
					pc_d = pc_inc + PC_W'({7'h00, ACC});
					flush_d = 1'b1;
				end
				OP_CALL:
				begin
					push_d.push = 1'b1;
					push_d.ret_addr = pc_inc;
					pc_d = {PC_HIGH_LATCH[LATCH_MSB:LATCH_LSB], INSTR.target};
					flush_d = 1'b1;
				end
				OP_NONE:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pc_q <= PC_RESET;
			flush_q <= 1'b0;
			fwrite_q <= '0;
			push_q <= '0;
		end
		else
		begin
			pc_q <= pc_d;
			flush_q <= flush_d;
			fwrite_q <= fwrite_d;
			push_q <= push_d;
		end
	end

	assign PC = pc_q;
	assign FLUSH = flush_q;
	assign FWRITE = fwrite_q;
	assign STACK_PUSH = push_q;
	assign FLAGS_WE = 1'b0;

	sequence s_call_taken;
		exec && INSTR.op == OP_CALL;
	endsequence

	sequence s_flush_slot;
		FLUSH && !FWRITE.wr ##1 !FWRITE.wr && !STACK_PUSH.push;
	endsequence

	clear_bit_value_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_CLEAR_BIT |=> FWRITE.wr && !FWRITE.data[$past(INSTR.bit_pos)]
		&& ((FWRITE.data | bit_mask($past(INSTR.bit_pos))) == ($past(FREG_RDATA) | bit_mask($past(INSTR.bit_pos)))))
		else $error("clear-bit result wrong");
	set_bit_value_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_SET_BIT |=> FWRITE.wr
		&& FWRITE.data == ($past(FREG_RDATA) | bit_mask($past(INSTR.bit_pos))))
		else $error("set-bit result wrong");
	skip_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_TEST_SKIP_CLEAR |=> FLUSH == !$past(tested))
		else $error("skip-if-clear decision wrong");
	skip_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_TEST_SKIP_SET |=> FLUSH == $past(tested))
		else $error("skip-if-set decision wrong");
	jump_literal_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_JUMP_LITERAL |=> FLUSH
		&& PC == $past(pc_q) + 15'h0001 + PC_W'({{(PC_W-REL_W){$past(INSTR.rel_k[REL_W-1])}}, $past(INSTR.rel_k)}))
		else $error("literal jump target wrong");
	jump_acc_a: assert property (@(posedge CLK) disable iff (!RST_N)
		exec && INSTR.op == OP_JUMP_ACC |=> FLUSH && PC == $past(pc_q) + 15'h0001 + PC_W'($past(ACC)))
		else $error("accumulator jump target wrong");
	call_push_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_call_taken |=> STACK_PUSH.push && STACK_PUSH.ret_addr == $past(pc_q) + 15'h0001 && FLUSH)
		else $error("call push wrong");
	call_target_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_call_taken |=> PC == {$past(PC_HIGH_LATCH[LATCH_MSB:LATCH_LSB]), $past(INSTR.target)})
		else $error("call target wrong");
	flushed_noop_a: assert property (@(posedge CLK) disable iff (!RST_N)
		FLUSH |=> !FWRITE.wr && !STACK_PUSH.push && !FLUSH && PC == $past(PC) + 15'h0001)
		else $error("flushed slot had effects");
	flush_pair_a: assert property (@(posedge CLK) disable iff (!RST_N)
		FLUSH |-> s_flush_slot)
		else $error("flushed slot wrote a register");

	// Slots that must behave as a plain step: nothing written, nothing pushed
	sequence s_plain_slot;
		!exec || INSTR.op == OP_NONE;
	endsequence

	sequence s_bit_op_taken;
		exec && (INSTR.op == OP_CLEAR_BIT || INSTR.op == OP_SET_BIT);
	endsequence

	sequence s_skip_taken;
		exec && ((INSTR.op == OP_TEST_SKIP_CLEAR && !tested)
		|| (INSTR.op == OP_TEST_SKIP_SET && tested));
	endsequence

	sequence s_skip_passed;
		exec && ((INSTR.op == OP_TEST_SKIP_CLEAR && tested)
		|| (INSTR.op == OP_TEST_SKIP_SET && !tested));
	endsequence

	sequence s_jump_taken;
		exec && (INSTR.op == OP_JUMP_LITERAL || INSTR.op == OP_JUMP_ACC);
	endsequence

	// Second cycle of a two-cycle op: flagged slot, then a clean slot
	sequence s_two_cycle;
		FLUSH && !FWRITE.wr ##1 !FLUSH && !FWRITE.wr && !STACK_PUSH.push;
	endsequence

	bit_op_target_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_bit_op_taken |=> FWRITE.addr == $past(INSTR.faddr) && !FLUSH && !STACK_PUSH.push)
		else $error("bit operation wrote the wrong register");

	skip_two_cycle_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_skip_taken |=> s_two_cycle)
		else $error("skipped slot was not a no-op");

	skip_passed_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_skip_passed |=> !FLUSH && PC == $past(pc_q) + 15'h0001)
		else $error("bit test skipped when it should not");

	jump_two_cycle_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_jump_taken |=> s_two_cycle)
		else $error("jump did not take two cycles");

	call_two_cycle_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_call_taken |=> s_two_cycle)
		else $error("call did not take two cycles");

	plain_slot_a: assert property (@(posedge CLK) disable iff (!RST_N)
		s_plain_slot |=> !FLUSH && !FWRITE.wr && !STACK_PUSH.push
		&& PC == $past(pc_q) + 15'h0001)
		else $error("idle slot had effects");

	write_source_a: assert property (@(posedge CLK) disable iff (!RST_N)
		FWRITE.wr |-> $past(exec) && ($past(INSTR.op) == OP_CLEAR_BIT
		|| $past(INSTR.op) == OP_SET_BIT))
		else $error("file write without a bit operation");

	push_source_a: assert property (@(posedge CLK) disable iff (!RST_N)
		STACK_PUSH.push |-> $past(exec) && $past(INSTR.op) == OP_CALL)
		else $error("stack push without a call");

	flush_source_a: assert property (@(posedge CLK) disable iff (!RST_N)
		FLUSH |-> $past(exec) && $past(INSTR.op) != OP_NONE
		&& $past(INSTR.op) != OP_CLEAR_BIT && $past(INSTR.op) != OP_SET_BIT)
		else $error("flush without a two-cycle op");
endmodule : bbx_exec

// [hdl/bbx_pkg.sv]
package bbx_pkg;
	localparam int PC_W = 15;
	localparam int FADDR_W = 7;
	localparam logic [6:0] FADDR_MAX = 7'h7f;
	localparam int BIT_POS_LSB = 7;
	localparam int LATCH_LSB = 3;
	localparam int LATCH_MSB = 6;
	localparam int TARGET_W = 11;
	localparam int REL_W = 9;
	localparam int BRANCH_CYCLES = 2;
	localparam logic [PC_W-1:0] PC_RESET = 15'h0000;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_CLEAR_BIT,
		OP_SET_BIT,
		OP_TEST_SKIP_CLEAR,
		OP_TEST_SKIP_SET,
		OP_JUMP_LITERAL,
		OP_JUMP_ACC,
		OP_CALL
	} bbx_op_t;

	typedef struct packed {
		logic valid;
		bbx_op_t op;
		logic [FADDR_W-1:0] faddr;
		logic [2:0] bit_pos;
		logic [REL_W-1:0] rel_k;
		logic [TARGET_W-1:0] target;
	} bbx_instr_t;

	typedef struct packed {
		logic wr;
		logic [FADDR_W-1:0] addr;
		logic [7:0] data;
	} bbx_fwrite_t;

	typedef struct packed {
		logic push;
		logic [PC_W-1:0] ret_addr;
	} bbx_push_t;
endpackage : bbx_pkg

// [verification/bbx_regfile.sv]
`timescale 1ns/1ps
module bbx_regfile
	import bbx_pkg::*;
(
	input wire logic clk, // Core clock
	input wire bbx_fwrite_t fwrite, // Write port
	input wire logic [6:0] raddr, // Read address
	output logic [7:0] rdata // Read data
);
	logic [7:0] mem_q [128];
	initial
	begin
		for (int a = 0; a < 128; a++)
			mem_q[a] = 8'(a * 37);
	end
	// Combinational read, so a write shows one cycle later
	assign rdata = mem_q[raddr];
	always @(posedge clk)
		if (fwrite.wr)
			mem_q[fwrite.addr] <= fwrite.data;
endmodule : bbx_regfile

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import bbx_pkg::*;
	logic CLK, RST_N, FLUSH, FLAGS_WE;
	bbx_instr_t INSTR;
	logic [7:0] ACC, LATCH, rd;
	logic [PC_W-1:0] PC;
	bbx_fwrite_t FW;
	bbx_push_t PUSH;
	int num_errors = 0;
	int cmp_count = 0;
	bbx_exec bbx_exec_inst(.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR), .FREG_RDATA(rd),
		.ACC(ACC), .PC_HIGH_LATCH(LATCH), .PC(PC), .FLUSH(FLUSH), .FWRITE(FW),
		.STACK_PUSH(PUSH), .FLAGS_WE(FLAGS_WE));
	bbx_regfile bbx_regfile_inst(.clk(CLK), .fwrite(FW), .raddr(INSTR.faddr), .rdata(rd));
	initial
	begin
		CLK = 0;
		forever #10 CLK = ~CLK;
	end
	task chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (e !== g)
		begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task end_of_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// Op, then a set-bit in the following slot to see whether it was flushed
	// The slot targets a register no scenario op uses, so its write never races the op's
	task run(bbx_op_t op, logic [6:0] f, logic [2:0] b, logic [8:0] k, logic [10:0] t);
		logic [PC_W-1:0] p;
		logic [PC_W-1:0] pc_exp;
		logic [7:0] v;
		logic [7:0] v_slot;
		logic [7:0] d_exp;
		logic fl;
		@(posedge CLK);
		INSTR <= '{1'b1, op, f, b, k, t};
		#1;
		p = PC;
		v = rd;
		fl = op inside {OP_JUMP_LITERAL, OP_JUMP_ACC, OP_CALL} ||
			(op == OP_TEST_SKIP_CLEAR && !v[b]) || (op == OP_TEST_SKIP_SET && v[b]);
		pc_exp = p + 15'h0001;
		if (op == OP_JUMP_LITERAL)
			pc_exp = p + 15'h0001 + {{6{k[8]}}, k};
		else if (op == OP_JUMP_ACC)
			pc_exp = p + 15'h0001 + {7'h00, ACC};
		else if (op == OP_CALL)
			pc_exp = {LATCH[6:3], t};
		d_exp = (op == OP_SET_BIT) ? (v | (8'h01 << b)) : (v & ~(8'h01 << b));
		@(posedge CLK);
		INSTR <= '{1'b1, OP_SET_BIT, 7'h40, 3'h0, 9'h0, 11'h0};
		#1;
		v_slot = rd;
		chk("pc", {1'b0, pc_exp}, {1'b0, PC});
		chk("flush", {15'h0000, fl}, {15'h0000, FLUSH});
		chk("wr", {15'h0000, op inside {OP_CLEAR_BIT, OP_SET_BIT}}, {15'h0000, FW.wr});
		if (op inside {OP_CLEAR_BIT, OP_SET_BIT})
			chk("fw", {1'b0, f, d_exp}, {1'b0, FW.addr, FW.data});
		chk("push", op == OP_CALL ? {1'b1, p + 15'h0001} : 16'h0000, op == OP_CALL ? PUSH : {PUSH.push, 15'h0000});
		p = PC;
		@(posedge CLK);
		INSTR.valid <= 1'b0;
		#1;
		chk("slot", {15'h0000, !fl}, {15'h0000, FW.wr});
		if (!fl)
			chk("slot_fw", {8'h40, v_slot | 8'h01}, {1'b0, FW.addr, FW.data});
		chk("pc1", {1'b0, p + 15'h0001}, {1'b0, PC});
		chk("flags", 16'h0000, {15'h0000, FLAGS_WE});
	endtask : run
	task bit_ops;
		for (int b = 0; b < 8; b++)
		begin
			run(OP_SET_BIT, 7'h7f, 3'(b), 9'h0, 11'h0);
			run(OP_CLEAR_BIT, 7'h00, 3'(b), 9'h0, 11'h0);
		end
	endtask : bit_ops
	task skips;
		for (int s = 0; s < 2; s++)
		begin
			run(s ? OP_SET_BIT : OP_CLEAR_BIT, 7'h05, 3'h2, 9'h0, 11'h0);
			run(OP_TEST_SKIP_CLEAR, 7'h05, 3'h2, 9'h0, 11'h0);
			run(OP_TEST_SKIP_SET, 7'h05, 3'h2, 9'h0, 11'h0);
		end
	endtask : skips
	task jumps;
		@(posedge CLK);
		ACC <= 8'hff;
		LATCH <= 8'hbd;
		run(OP_NONE, 7'h0, 3'h0, 9'h0, 11'h0);
		run(OP_JUMP_LITERAL, 7'h0, 3'h0, 9'h100, 11'h0);
		run(OP_JUMP_LITERAL, 7'h0, 3'h0, 9'h0ff, 11'h0);
		run(OP_JUMP_ACC, 7'h0, 3'h0, 9'h0, 11'h0);
		run(OP_CALL, 7'h0, 3'h0, 9'h0, 11'h7ff);
	endtask : jumps
	// Reset in mid-run: outputs clear at once and the PC restarts from its reset value
	task reset_mid;
		@(posedge CLK);
		RST_N <= 1'b0;
		#1;
		chk("rst_pc", {1'b0, PC_RESET}, {1'b0, PC});
		chk("rst_out", 16'h0000, {13'h0000, FLUSH, FW.wr, PUSH.push});
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		#1;
		chk("rel_pc", {1'b0, PC_RESET + 15'h0001}, {1'b0, PC});
	endtask : reset_mid
	initial
	begin
		RST_N = 1'b0;
		INSTR = '0;
		ACC = 8'h00;
		LATCH = 8'h00;
		repeat (16) @(posedge CLK);
		chk("pc_rst", PC_RESET, PC);
		RST_N <= 1'b1;
		bit_ops;
		reset_mid;
		skips;
		jumps;
		end_of_test;
	end
endmodule : testbench
